// [common/rrt_consts.svh]
// constants for the retransmit receive supervision block
// What this block does
// - count sequence changes after a discontinuity; beyond limit is wrap
// - wrap condition raises the wrap fault and is a fatal error
// - wrap limit zero means the wrap detector is off
// - 32-bit watchdog counts received words while awaiting expected sequence
// - watchdog reaching its limit first raises the timeout fault, fatal
// - watchdog limit zero disables the watchdog
// - acknowledge pulse clears the replay request output
// - request must return low before any further request is raised
// - burst error in the last standard burst is reported, otherwise ignored
// - burst error at other times is handled like a CRC24 error
// - fatal error reports state 110 and waits for the recover input
// - waiting for the expected sequence reports state 101
`ifndef RRT_CONSTS_SVH
`define RRT_CONSTS_SVH

// ************************************************************
// register map
// ************************************************************
`define RRT_ADDR_WRAP_LIMIT   12'h000
`define RRT_ADDR_WDOG_LIMIT   12'h004
`define RRT_ADDR_STATUS       12'h008
`define RRT_ADDR_CLEAR        12'h00c

// ************************************************************
// state codes and field positions
// ************************************************************
`define RRT_ST_NORMAL         3'h1
`define RRT_ST_RETRY          3'h2
`define RRT_ST_WAIT_SEQ       3'h5
`define RRT_ST_FATAL_ASSERT   3'h6
`define RRT_ST_FATAL_NEGATE   3'h7
`define RRT_WRAP_LIMIT_RESET  8'h00
`define RRT_WDOG_LIMIT_RESET  32'h0000_0000
`define RRT_STAT_WRAP_BIT     0
`define RRT_STAT_WDOG_BIT     1
`define RRT_STAT_BURST_BIT    2
`define RRT_STAT_REQ_BIT      3
`define RRT_STAT_STATE_LSB    4

`endif

// [common/rrt_pkg.sv]
// types for the retransmit receive supervision block
package rrt_pkg;

   typedef enum logic [1:0] {
      RRT_NORMAL,
      RRT_RETRY,
      RRT_WAIT_SEQ,
      RRT_FATAL
   } rrt_state_t;

   // receive-path events, all one-cycle pulses on pclk
   typedef struct packed {
      logic crc_err;
      logic burst_err;
      logic last_std_burst;
      logic discontinuity;
      logic expected_seq;
      logic seq_changed;
      logic word_valid;
      logic fatal_in;
   } rrt_rx_ev_t;

   // fault outputs
   typedef struct packed {
      logic seq_overrun_fault;
      logic expected_seq_timeout_fault;
      logic burst_fault;
   } rrt_fault_t;

endpackage

// [core/rrt_supervisor.sv]
// retransmit receive supervision: wrap and watchdog detectors, request
`timescale 1ns/1ps
`include "rrt_consts.svh"

module rrt_supervisor
   import rrt_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire rrt_rx_ev_t  rx_ev,
   input  wire logic        request_sent_ack,
   input  wire logic        replay_recover_in,
   output logic             replay_request_out,
   output logic      [2:0]  replay_fsm_state,
   output rrt_fault_t       faults
);

   // ************************************************************
   // apb slave
   // ************************************************************
   logic [7:0]  seq_change_limit_q, seq_change_limit_d;
   logic [31:0] expected_seq_word_limit_q, expected_seq_word_limit_d;
   logic [31:0] prdata_q, prdata_d;
   logic        pslverr_d;
   logic        acc, wr_clr;
   logic        mapped;
   rrt_fault_t  sticky_q, sticky_d;

   assign acc     = psel && penable;
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_d;

   always_comb begin
      mapped = (paddr == `RRT_ADDR_WRAP_LIMIT) ||
               (paddr == `RRT_ADDR_WDOG_LIMIT) ||
               (paddr == `RRT_ADDR_STATUS) ||
               (paddr == `RRT_ADDR_CLEAR);
      pslverr_d = acc && !mapped;
      seq_change_limit_d = seq_change_limit_q;
      expected_seq_word_limit_d = expected_seq_word_limit_q;
      wr_clr = 1'b0;
      prdata_d = prdata_q;
      if (acc && pwrite) begin
         case (paddr)
            `RRT_ADDR_WRAP_LIMIT: seq_change_limit_d = pwdata[7:0];
            `RRT_ADDR_WDOG_LIMIT: expected_seq_word_limit_d = pwdata;
            `RRT_ADDR_CLEAR:      wr_clr = pwdata[0];
            default: ;
         endcase
      end
      // read data is latched at the setup edge so that it stands from a
      // flop through the access cycle; status is the view at setup
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `RRT_ADDR_WRAP_LIMIT: prdata_d = {24'h000000, seq_change_limit_q};
            `RRT_ADDR_WDOG_LIMIT: prdata_d = expected_seq_word_limit_q;
            `RRT_ADDR_STATUS: begin
               prdata_d = 32'h0000_0000;
               prdata_d[`RRT_STAT_WRAP_BIT]  = sticky_q.seq_overrun_fault;
               prdata_d[`RRT_STAT_WDOG_BIT]  =
                  sticky_q.expected_seq_timeout_fault;
               prdata_d[`RRT_STAT_BURST_BIT] = sticky_q.burst_fault;
               prdata_d[`RRT_STAT_REQ_BIT]   = replay_request_out;
               prdata_d[`RRT_STAT_STATE_LSB +: 3] = replay_fsm_state;
            end
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_change_limit_q        <= `RRT_WRAP_LIMIT_RESET;
         expected_seq_word_limit_q <= `RRT_WDOG_LIMIT_RESET;
         prdata_q                  <= 32'h0000_0000;
      end else begin
         seq_change_limit_q        <= seq_change_limit_d;
         expected_seq_word_limit_q <= expected_seq_word_limit_d;
         prdata_q                  <= prdata_d;
      end
   end

   // ************************************************************
   // retransmission state machine
   // ************************************************************
   rrt_state_t  state_q, state_d;
   logic [7:0]  wrap_cnt_q, wrap_cnt_d;
   logic [31:0] wdog_cnt_q, wdog_cnt_d;
   logic        req_q, req_d;
   logic        pend_q, pend_d;
   logic        recover_seen_q, recover_seen_d;
   logic        burst_as_crc, burst_flag, retx_trigger;
   logic        wrap_hit, wdog_hit, fatal_now;
   rrt_fault_t  fault_d, fault_q;

   always_comb begin
      // a burst error right before replay data is only reported
      burst_flag   = rx_ev.burst_err;
      burst_as_crc = rx_ev.burst_err && !rx_ev.last_std_burst;
      retx_trigger = rx_ev.crc_err || burst_as_crc;
      // counters run only in the wait state; the wrap hit compares the current
      // count and the watchdog hit the next count so the wrap fault appears on the edge that exceeds and the
      // watchdog fault on the edge that meets the limit
      wrap_hit = (state_q == RRT_WAIT_SEQ) &&
                 (seq_change_limit_q != 8'h00) && rx_ev.seq_changed &&
                 !rx_ev.expected_seq &&
                 (wrap_cnt_q >= seq_change_limit_q);
      wdog_hit = (state_q == RRT_WAIT_SEQ) &&
                 (expected_seq_word_limit_q != 32'h0000_0000) &&
                 rx_ev.word_valid && !rx_ev.expected_seq &&
                 (wdog_cnt_q + 32'h1 >= expected_seq_word_limit_q);
      fatal_now = wrap_hit || wdog_hit || rx_ev.fatal_in;

      state_d        = state_q;
      wrap_cnt_d     = wrap_cnt_q;
      wdog_cnt_d     = wdog_cnt_q;
      recover_seen_d = recover_seen_q;
      fault_d        = '0;
      fault_d.burst_fault = burst_flag;
      case (state_q)
         RRT_NORMAL: begin
            if (rx_ev.fatal_in) begin
               state_d = RRT_FATAL;
            end else if (retx_trigger) begin
               state_d = RRT_RETRY;
            end
         end
         RRT_RETRY: begin
            if (rx_ev.fatal_in) begin
               state_d = RRT_FATAL;
            end else if (rx_ev.discontinuity) begin
               state_d    = RRT_WAIT_SEQ;
               wrap_cnt_d = 8'h00;
               wdog_cnt_d = 32'h0000_0000;
            end
         end
         RRT_WAIT_SEQ: begin
            if (fatal_now) begin
               state_d = RRT_FATAL;
               fault_d.seq_overrun_fault = wrap_hit;
               fault_d.expected_seq_timeout_fault = wdog_hit;
            end else if (rx_ev.expected_seq) begin
               state_d    = RRT_NORMAL;
               wrap_cnt_d = 8'h00;
               wdog_cnt_d = 32'h0000_0000;
            end else begin
               if (rx_ev.seq_changed) begin
                  wrap_cnt_d = wrap_cnt_q + 8'h01;
               end
               if (rx_ev.word_valid) begin
                  wdog_cnt_d = wdog_cnt_q + 32'h1;
               end
            end
         end
         RRT_FATAL: begin
            // leave on release of the recover input after it was seen
            if (replay_recover_in) begin
               recover_seen_d = 1'b1;
            end else if (recover_seen_q) begin
               recover_seen_d = 1'b0;
               state_d        = RRT_NORMAL;
            end
         end
         default: state_d = RRT_NORMAL;
      endcase
   end

   // request: set on a trigger, cleared by the ack; a trigger seen while
   // the request is high waits until the bit has gone low for a cycle
   always_comb begin
      req_d  = req_q;
      pend_d = pend_q;
      if (req_q && request_sent_ack) begin
         req_d = 1'b0;
      end
      if ((state_q == RRT_NORMAL) && retx_trigger && !rx_ev.fatal_in) begin
         if (req_q) begin
            pend_d = 1'b1;
         end else begin
            // a fresh trigger absorbs any pended one
            req_d  = 1'b1;
            pend_d = 1'b0;
         end
      end else if (pend_q && !req_q) begin
         req_d  = 1'b1;
         pend_d = 1'b0;
      end
      if (state_q == RRT_FATAL) begin
         pend_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q        <= RRT_NORMAL;
         wrap_cnt_q     <= 8'h00;
         wdog_cnt_q     <= 32'h0000_0000;
         req_q          <= 1'b0;
         pend_q         <= 1'b0;
         recover_seen_q <= 1'b0;
         fault_q        <= '0;
         sticky_q       <= '0;
      end else begin
         state_q        <= state_d;
         wrap_cnt_q     <= wrap_cnt_d;
         wdog_cnt_q     <= wdog_cnt_d;
         req_q          <= req_d;
         pend_q         <= pend_d;
         recover_seen_q <= recover_seen_d;
         fault_q        <= fault_d;
         sticky_q       <= sticky_d;
      end
   end

   // sticky copies for software; a new fault wins over a clear
   always_comb begin
      sticky_d = wr_clr ? rrt_fault_t'(3'b000) : sticky_q;
      sticky_d = sticky_d | fault_d;
   end

   // ************************************************************
   // outputs
   // ************************************************************
   always_comb begin
      case (state_q)
         RRT_NORMAL:   replay_fsm_state = `RRT_ST_NORMAL;
         RRT_RETRY:    replay_fsm_state = `RRT_ST_RETRY;
         RRT_WAIT_SEQ: replay_fsm_state = `RRT_ST_WAIT_SEQ;
         RRT_FATAL:    replay_fsm_state = recover_seen_q ?
                          `RRT_ST_FATAL_NEGATE : `RRT_ST_FATAL_ASSERT;
         default:      replay_fsm_state = `RRT_ST_NORMAL;
      endcase
   end
   assign replay_request_out = req_q;
   assign faults             = fault_q;

   // ************************************************************
   // assertions
   // ************************************************************
   // every property here runs on pclk and sleeps through reset
   default clocking assert_clk @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_wrap_to_fatal: assert property (
      faults.seq_overrun_fault |-> replay_fsm_state == `RRT_ST_FATAL_ASSERT)
      else $error("wrap fault without fatal state");
   a_wrap_needs_limit: assert property (
      $rose(faults.seq_overrun_fault) |-> $past(seq_change_limit_q) != 8'h00)
      else $error("wrap fault with detector off");
   a_wdog_needs_limit: assert property (
      faults.expected_seq_timeout_fault |->
      $past(expected_seq_word_limit_q) != 32'h0000_0000)
      else $error("watchdog fault while disabled");
   a_wdog_to_fatal: assert property (
      faults.expected_seq_timeout_fault |->
      replay_fsm_state == `RRT_ST_FATAL_ASSERT)
      else $error("watchdog fault without fatal");
   a_ack_clears_req: assert property (
      (replay_request_out && request_sent_ack && !pend_q) |=>
      !replay_request_out)
      else $error("ack did not clear request");
   a_req_gap: assert property (
      (replay_request_out && request_sent_ack && pend_q &&
       state_q != RRT_FATAL) |=> !replay_request_out ##1 replay_request_out)
      else $error("pended request without a low cycle");
   a_burst_report: assert property (
      rx_ev.burst_err |=> faults.burst_fault)
      else $error("burst error not reported");
   a_last_burst_quiet: assert property (
      (state_q == RRT_NORMAL && rx_ev.burst_err && rx_ev.last_std_burst &&
       !rx_ev.crc_err && !rx_ev.fatal_in) |=> state_q == RRT_NORMAL)
      else $error("last burst error acted on");
   a_burst_as_crc: assert property (
      (state_q == RRT_NORMAL && rx_ev.burst_err && !rx_ev.last_std_burst &&
       !rx_ev.fatal_in) |=> state_q == RRT_RETRY)
      else $error("burst error not treated as crc");
   a_wait_code: assert property (
      state_q == RRT_WAIT_SEQ |-> replay_fsm_state == `RRT_ST_WAIT_SEQ)
      else $error("wait state code wrong");
   a_count_clear: assert property (
      $rose(state_q == RRT_WAIT_SEQ) |->
      wrap_cnt_q == 8'h00 && wdog_cnt_q == 32'h0000_0000)
      else $error("counters not cleared");
   a_wrap_count: assert property (
      (state_q == RRT_WAIT_SEQ && rx_ev.seq_changed && !fatal_now &&
       !rx_ev.expected_seq) |=> wrap_cnt_q == $past(wrap_cnt_q) + 8'h01)
      else $error("wrap counter missed change");

   c_wrap: cover property ($rose(faults.seq_overrun_fault));
   c_wdog: cover property ($rose(faults.expected_seq_timeout_fault));
   c_req_ack: cover property (replay_request_out ##[1:20] request_sent_ack);
   c_req_pend: cover property (
      $fell(replay_request_out) ##1 replay_request_out);
   c_recover: cover property (
      replay_fsm_state == `RRT_ST_FATAL_NEGATE ##1
      replay_fsm_state == `RRT_ST_NORMAL);

endmodule

// [verif/rrt_fc_tx_model.sv]
// flow control transmitter model: one calendar slot for replay requests
`timescale 1ns/1ps

module rrt_fc_tx_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       calendar_status_in,
   input  wire logic [3:0] cal_len,
   output logic            request_sent_ack
);
   logic [4:0] cnt;
   logic       sent;

   // ack comes from the same slot that carried the request bit
   // a slot is sent once per request; a new one needs a low first
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
         sent <= 1'b0;
         request_sent_ack <= 1'b0;
      end else begin
         request_sent_ack <= (cnt == 5'h01);
         if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
         end else if (calendar_status_in && !sent) begin
            cnt <= {1'b0, cal_len} + 5'h01;
         end
         // slot marked sent until the request bit is seen low again
         sent <= calendar_status_in && (sent || cnt == 5'h00);
      end
   end
endmodule

// [verif/rrt_supervisor_tb.sv]
// self-checking bench for the retransmit receive supervision block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module rrt_supervisor_tb
   import rrt_pkg::*;
();
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd, rdat;
   rrt_rx_ev_t  rx_ev;
   rrt_fault_t  faults;
   logic        ack, rin, req, serr;
   logic [2:0]  fsm, m_st, m_stk;
   logic [3:0]  cal_len;
   int          errors, checks, m_lim, m_wdl, m_wc, m_wd, lim, wdl, n;

   rrt_supervisor i_rrt_supervisor (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_ev(rx_ev), .request_sent_ack(ack),
      .replay_recover_in(rin), .replay_request_out(req),
      .replay_fsm_state(fsm), .faults(faults));

   rrt_fc_tx_model i_rrt_fc_tx_model (.pclk(pclk), .presetn(presetn),
      .calendar_status_in(req), .cal_len(cal_len),
      .request_sent_ack(ack));

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [31:0] xs();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      serr = pslverr;
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // read data and error flag are taken at the access edge itself
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic ee);
      apb(1'b0, a, 32'h0);
      `CHK(rdat, e)
      `CHK(serr, ee)
   endtask

   function automatic logic [31:0] stat();
      return {25'h0, m_st, 1'b0, m_stk[0], m_stk[1], m_stk[2]};
   endfunction

   // model step: fault bits are {wrap, watchdog, burst}
   task automatic evm(input logic [7:0] e);
      logic [2:0] f;
      f = {2'b00, e[6]};
      case (m_st)
         3'h1: begin
            if (e[0]) begin
               m_st = 3'h6;
            end else if (e[7] || (e[6] && !e[5])) begin
               m_st = 3'h2;
            end
         end
         3'h2: begin
            if (e[0]) begin
               m_st = 3'h6;
            end else if (e[4]) begin
               m_st = 3'h5;
               m_wc = 0;
               m_wd = 0;
            end
         end
         3'h5: begin
            // a change past the limit, or the word that meets it, is fatal
            if (!e[3] && e[2] && m_lim != 0 && m_wc + 1 > m_lim) f[2] = 1'b1;
            if (!e[3] && e[1] && m_wdl != 0 && m_wd + 1 == m_wdl) f[1] = 1'b1;
            if (f[2] || f[1] || e[0]) begin
               m_st = 3'h6;
            end else if (e[3]) begin
               m_st = 3'h1;
               m_wc = 0;
               m_wd = 0;
            end else begin
               m_wc = m_wc + int'(e[2]);
               m_wd = m_wd + int'(e[1]);
            end
         end
         default: ;
      endcase
      m_stk = m_stk | f;
      @(posedge pclk);
      rx_ev <= rrt_rx_ev_t'(e);
      @(posedge pclk);
      rx_ev <= '0;
      #1;
      `CHK(faults, rrt_fault_t'(f))
      `CHK(fsm, m_st)
   endtask

   task automatic ackw();
      n = 0;
      while (req !== 1'b0 && n < 60) begin
         @(posedge pclk);
         #1;
         n++;
      end
      `CHK(req, 1'b0)
   endtask

   task automatic recover();
      @(posedge pclk);
      rin <= 1'b1;
      @(posedge pclk);
      #1;
      `CHK(fsm, 3'h7)
      @(posedge pclk);
      rin <= 1'b0;
      @(posedge pclk);
      #1;
      m_st = 3'h1;
      `CHK(fsm, m_st)
   endtask

   task complete_run;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ************************************************************
   // clock, watchdog and scenarios
   // ************************************************************
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      complete_run();
   end

   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
      pwdata = '0; rx_ev = '0; rin = 0; rnd = 32'd77138;
      errors = 0; checks = 0; m_st = 3'h1; m_stk = '0;
      m_lim = 0; m_wdl = 0; m_wc = 0; m_wd = 0;
      cal_len = 4'(xs() % 6);
      // non-zero and below every channel-extension bound
      lim = 1 + int'(xs() % 8);
      wdl = 2 + int'(xs() % 30);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h000, 32'h0, 1'b0);
      rd(12'h004, 32'h0, 1'b0);
      rd(12'h008, stat(), 1'b0);
      rd(12'h010, 32'h0, 1'b1);
      apb(1'b1, 12'h000, 32'(lim));
      m_lim = lim;
      rd(12'h000, 32'(lim), 1'b0);
      apb(1'b1, 12'h004, 32'(wdl));
      m_wdl = wdl;
      rd(12'h004, 32'(wdl), 1'b0);
      evm(8'h60);
      evm(8'h40);
      `CHK(req, 1'b1)
      ackw();
      evm(8'h10);
      repeat (lim) evm(8'h04);
      evm(8'h04);
      rd(12'h008, stat(), 1'b0);
      apb(1'b1, 12'h00c, 32'h1);
      m_stk = '0;
      rd(12'h008, stat(), 1'b0);
      recover();
      evm(8'h80);
      `CHK(req, 1'b1)
      ackw();
      evm(8'h10);
      repeat (wdl - 1) evm(8'h02);
      evm(8'h08);
      evm(8'h80);
      ackw();
      evm(8'h10);
      repeat (wdl - 1) evm(8'h02);
      evm(8'h02);
      recover();
      evm(8'h01);
      recover();
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      m_lim = 0;
      m_wdl = 0;
      evm(8'h80);
      ackw();
      evm(8'h10);
      repeat (40) evm(8'h06);
      evm(8'h08);
      // a long calendar keeps the request up across a second trigger
      @(posedge pclk);
      cal_len <= 4'hf;
      evm(8'h80);
      evm(8'h10);
      evm(8'h08);
      evm(8'h80);
      ackw();
      @(posedge pclk);
      #1;
      `CHK(req, 1'b1)
      ackw();
      complete_run();
   end
endmodule
